// file: common/mpcd_pkg.sv
// Constants, types and shared decoding for the motion parameter command decoder.
// Assumes one 200 MHz clock domain; the frame byte source and the
// non-volatile memory port run on the same clock.

package mpcd_pkg;

  // ---------------------------------------------------------------
  // Frame layout and widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned AXIS_ADDR_W   = 8;
  localparam int unsigned GLOBAL_ADDR_W = 10;
  localparam logic [3:0]  LAST_BYTE_IDX = 4'h8;     // Nine bytes, index 0..8
  localparam logic [3:0]  FIRST_BYTE_IDX = 4'h0;

  // ---------------------------------------------------------------
  // Instruction codes of the parameter access group
  // ---------------------------------------------------------------
  localparam logic [7:0] INSTR_SET_AXIS      = 8'h05;
  localparam logic [7:0] INSTR_GET_AXIS      = 8'h06;
  localparam logic [7:0] INSTR_SET_GLOBAL    = 8'h09;
  localparam logic [7:0] INSTR_GET_GLOBAL    = 8'h0A;
  localparam logic [7:0] INSTR_STORE_UVAR    = 8'h0B;
  localparam logic [7:0] INSTR_RESTORE_UVAR  = 8'h0C;

  // ---------------------------------------------------------------
  // Banks, axis count, status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] BANK_MODULE    = 8'h00;
  localparam logic [7:0] BANK_USER      = 8'h02;
  localparam logic [7:0] BANK_IRQ       = 8'h03;
  localparam logic [7:0] AXIS_COUNT     = 8'h01;
  localparam logic [7:0] LAST_UVAR_IDX  = 8'hFF;
  localparam logic [7:0] STATUS_OK      = 8'h64;    // 100
  localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_BANK = 8'h03;
  localparam logic [7:0] STATUS_BAD_MOTOR = 8'h04;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [9:0]  RST_NVM_ADDR = 10'h000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_BOOT_REQ,
    ST_BOOT_WAIT,
    ST_RECV,
    ST_CHECK,
    ST_EXEC,
    ST_NVM_WAIT
  } mpcd_state_e_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  sel;       // Parameter number
    logic [7:0]  bank;      // Motor or bank
    logic [31:0] value;
  } mpcd_frame_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [9:0]  addr;
    logic [31:0] data;
  } mpcd_nvm_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
  } mpcd_reply_t;

  typedef struct packed {
    mpcd_state_e_t st;
    logic [7:0]    addrMeta;
    logic [7:0]    addrSync;
    logic          modeMeta;
    logic          modeSync;
    mpcd_frame_t   frame;
    logic [3:0]    byteCnt;
    logic [7:0]    sum;
    logic [7:0]    rxSum;
    logic [7:0]    bootIdx;
    mpcd_nvm_t     nvm;
    mpcd_reply_t   reply;
    logic [31:0]   accu;
    logic          rxReady;
  } mpcd_regs_t;

  localparam mpcd_regs_t RST_REGS = '{
    st:       ST_BOOT_REQ,
    addrMeta: RST_BYTE,
    addrSync: RST_BYTE,
    modeMeta: 1'b0,
    modeSync: 1'b0,
    frame:    '{addr: RST_BYTE, instr: RST_BYTE, sel: RST_BYTE, bank: RST_BYTE, value: RST_WORD},
    byteCnt:  FIRST_BYTE_IDX,
    sum:      RST_BYTE,
    rxSum:    RST_BYTE,
    bootIdx:  RST_BYTE,
    nvm:      '{req: 1'b0, write: 1'b0, addr: RST_NVM_ADDR, data: RST_WORD},
    reply:    '{valid: 1'b0, status: RST_BYTE, instr: RST_BYTE, value: RST_WORD},
    accu:     RST_WORD,
    rxReady:  1'b0
  };

  // ---------------------------------------------------------------
  // Shared decoding
  // ---------------------------------------------------------------
  // Global storage index: bank in the top two bits, parameter number below
  function automatic logic [9:0] globalIndex(input logic [7:0] bank, input logic [7:0] sel);
    globalIndex = {bank[1:0], sel};
  endfunction

  function automatic logic bankValid(input logic [7:0] bank);
    bankValid = (bank == BANK_MODULE) || (bank == BANK_USER) || (bank == BANK_IRQ);
  endfunction

endpackage

// file: src/mpcd_mem.sv
// Simple dual-port parameter store: one write port, one read port.
// Read data come out of a register one cycle after the read enable.
// Contents are volatile and undefined until first written.

`timescale 1ns/1ps
`default_nettype none

module mpcd_mem #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [31:0]       wrData,
  input  wire logic              rdEn,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output var  logic [31:0]       rdData
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] store [2**ADDR_W];

  // Array kept free of reset so it maps onto block memory
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
  end

  // Registered read port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData <= mpcd_pkg::RST_WORD;
    end
    else if (rdEn)
    begin
      rdData <= store[rdAddr];
    end
  end

endmodule

`default_nettype wire

// file: src/mpcd_top.sv
// Command frame decoder for axis and global parameter access.
// Assumes frame bytes arrive on the core clock with a valid strobe, and that
// a non-volatile memory controller on the same clock answers each request
// with a one-cycle acknowledge.

`timescale 1ns/1ps
`default_nettype none

module mpcd_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxValid,
  output var  logic        rxReady,
  input  wire logic [7:0]  serialAddr,
  input  wire logic        standaloneMode,
  output var  logic        replyValid,
  output var  logic [7:0]  replyStatus,
  output var  logic [7:0]  replyInstr,
  output var  logic [31:0] replyValue,
  output var  logic [31:0] accu,
  output var  logic        nvmReq,
  output var  logic        nvmWrite,
  output var  logic [9:0]  nvmAddr,
  output var  logic [31:0] nvmWrData,
  input  wire logic [31:0] nvmRdData,
  input  wire logic        nvmAck
);

  // ---------------------------------------------------------------
  // State and memory port signals
  // ---------------------------------------------------------------
  mpcd_pkg::mpcd_regs_t s_q;
  mpcd_pkg::mpcd_regs_t s_d;

  logic        axisWrEn;
  logic [7:0]  axisWrAddr;
  logic [31:0] axisWrData;
  logic        axisRdEn;
  logic [7:0]  axisRdAddr;
  logic [31:0] axisRdData;
  logic        globWrEn;
  logic [9:0]  globWrAddr;
  logic [31:0] globWrData;
  logic        globRdEn;
  logic [9:0]  globRdAddr;
  logic [31:0] globRdData;

  // ---------------------------------------------------------------
  // Parameter stores
  // ---------------------------------------------------------------
  // Axis values live only here, never in non-volatile memory
  mpcd_mem #(
    .ADDR_W (mpcd_pkg::AXIS_ADDR_W)
  ) u_axis_mem (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (axisWrEn),
    .wrAddr (axisWrAddr),
    .wrData (axisWrData),
    .rdEn   (axisRdEn),
    .rdAddr (axisRdAddr),
    .rdData (axisRdData)
  );

  // Global store: bank 0, user variables and interrupt configuration
  mpcd_mem #(
    .ADDR_W (mpcd_pkg::GLOBAL_ADDR_W)
  ) u_glob_mem (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (globWrEn),
    .wrAddr (globWrAddr),
    .wrData (globWrData),
    .rdEn   (globRdEn),
    .rdAddr (globRdAddr),
    .rdData (globRdData)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // One pass fills the next copy of all state and the memory strobes
  always_comb
  begin
    s_d = s_q;
    s_d.reply.valid = 1'b0;
    axisWrEn   = 1'b0;
    axisWrAddr = s_q.frame.sel;
    axisWrData = s_q.frame.value;
    axisRdEn   = 1'b0;
    axisRdAddr = s_q.frame.sel;
    globWrEn   = 1'b0;
    globWrAddr = mpcd_pkg::globalIndex(s_q.frame.bank, s_q.frame.sel);
    globWrData = s_q.frame.value;
    globRdEn   = 1'b0;
    globRdAddr = mpcd_pkg::globalIndex(s_q.frame.bank, s_q.frame.sel);

    // Pin-level inputs pass two flip-flops before use
    s_d.addrMeta = serialAddr;
    s_d.addrSync = s_q.addrMeta;
    s_d.modeMeta = standaloneMode;
    s_d.modeSync = s_q.modeMeta;

    case (s_q.st)
      // Walk every user variable out of non-volatile memory after reset
      mpcd_pkg::ST_BOOT_REQ:
      begin
        s_d.nvm.req   = 1'b1;
        s_d.nvm.write = 1'b0;
        s_d.nvm.addr  = mpcd_pkg::globalIndex(mpcd_pkg::BANK_USER, s_q.bootIdx);
        s_d.st        = mpcd_pkg::ST_BOOT_WAIT;
      end

      mpcd_pkg::ST_BOOT_WAIT:
      begin
        if (nvmAck)
        begin
          s_d.nvm.req = 1'b0;
          globWrEn    = 1'b1;
          globWrAddr  = s_q.nvm.addr;
          globWrData  = nvmRdData;
          if (s_q.bootIdx == mpcd_pkg::LAST_UVAR_IDX)
          begin
            s_d.st = mpcd_pkg::ST_RECV;
          end
          else
          begin
            s_d.bootIdx = s_q.bootIdx + 8'h01;
            s_d.st      = mpcd_pkg::ST_BOOT_REQ;
          end
        end
      end

      // Collect nine bytes in fixed order, summing the first eight
      mpcd_pkg::ST_RECV:
      begin
        if (rxValid)
        begin
          case (s_q.byteCnt)
            4'h0: s_d.frame.addr = rxByte;
            4'h1: s_d.frame.instr = rxByte;
            4'h2: s_d.frame.sel = rxByte;
            4'h3: s_d.frame.bank = rxByte;
            4'h4: s_d.frame.value[31:24] = rxByte;
            4'h5: s_d.frame.value[23:16] = rxByte;
            4'h6: s_d.frame.value[15:8] = rxByte;
            4'h7: s_d.frame.value[7:0] = rxByte;
            default: s_d.rxSum = rxByte;
          endcase
          if (s_q.byteCnt == mpcd_pkg::FIRST_BYTE_IDX)
          begin
            s_d.sum = rxByte;
          end
          else if (s_q.byteCnt != mpcd_pkg::LAST_BYTE_IDX)
          begin
            s_d.sum = s_q.sum + rxByte;
          end
          if (s_q.byteCnt == mpcd_pkg::LAST_BYTE_IDX)
          begin
            s_d.byteCnt = mpcd_pkg::FIRST_BYTE_IDX;
            s_d.st      = mpcd_pkg::ST_CHECK;
          end
          else
          begin
            s_d.byteCnt = s_q.byteCnt + 4'h1;
          end
        end
      end

      // Start both reads now so data are ready in the execute cycle
      mpcd_pkg::ST_CHECK:
      begin
        axisRdEn = 1'b1;
        globRdEn = 1'b1;
        if (s_q.frame.addr != s_q.addrSync)
        begin
          s_d.st = mpcd_pkg::ST_RECV;
        end
        else
        begin
          s_d.st = mpcd_pkg::ST_EXEC;
        end
      end

      mpcd_pkg::ST_EXEC:
      begin
        s_d.st           = mpcd_pkg::ST_RECV;
        s_d.reply.instr  = s_q.frame.instr;
        s_d.reply.status = mpcd_pkg::STATUS_OK;
        s_d.reply.value  = mpcd_pkg::RST_WORD;
        if (s_q.sum != s_q.rxSum)
        begin
          s_d.reply.status = mpcd_pkg::STATUS_BAD_SUM;
        end
        else
        begin
          case (s_q.frame.instr)
            mpcd_pkg::INSTR_SET_AXIS:
            begin
              if (s_q.frame.bank < mpcd_pkg::AXIS_COUNT)
              begin
                axisWrEn = 1'b1;
              end
              else
              begin
                s_d.reply.status = mpcd_pkg::STATUS_BAD_MOTOR;
              end
            end
            mpcd_pkg::INSTR_GET_AXIS:
            begin
              if (s_q.frame.bank < mpcd_pkg::AXIS_COUNT)
              begin
                s_d.reply.value = axisRdData;
                if (s_q.modeSync)
                begin
                  s_d.accu = axisRdData;
                end
              end
              else
              begin
                s_d.reply.status = mpcd_pkg::STATUS_BAD_MOTOR;
              end
            end
            mpcd_pkg::INSTR_SET_GLOBAL:
            begin
              if (!mpcd_pkg::bankValid(s_q.frame.bank))
              begin
                s_d.reply.status = mpcd_pkg::STATUS_BAD_BANK;
              end
              else
              begin
                globWrEn = 1'b1;
                if (s_q.frame.bank == mpcd_pkg::BANK_MODULE)
                begin
                  // Reply waits until the commit is acknowledged
                  s_d.nvm = '{req: 1'b1, write: 1'b1, addr: globWrAddr, data: s_q.frame.value};
                  s_d.st  = mpcd_pkg::ST_NVM_WAIT;
                end
              end
            end
            mpcd_pkg::INSTR_GET_GLOBAL:
            begin
              if (!mpcd_pkg::bankValid(s_q.frame.bank))
              begin
                s_d.reply.status = mpcd_pkg::STATUS_BAD_BANK;
              end
              else
              begin
                s_d.reply.value = globRdData;
                s_d.accu        = globRdData;
              end
            end
            mpcd_pkg::INSTR_STORE_UVAR:
            begin
              if (s_q.frame.bank != mpcd_pkg::BANK_USER)
              begin
                s_d.reply.status = mpcd_pkg::STATUS_BAD_BANK;
              end
              else
              begin
                s_d.nvm = '{req: 1'b1, write: 1'b1, addr: globRdAddr, data: globRdData};
                s_d.st  = mpcd_pkg::ST_NVM_WAIT;
              end
            end
            mpcd_pkg::INSTR_RESTORE_UVAR:
            begin
              if (s_q.frame.bank != mpcd_pkg::BANK_USER)
              begin
                s_d.reply.status = mpcd_pkg::STATUS_BAD_BANK;
              end
              else
              begin
                s_d.nvm = '{req: 1'b1, write: 1'b0, addr: globRdAddr, data: mpcd_pkg::RST_WORD};
                s_d.st  = mpcd_pkg::ST_NVM_WAIT;
              end
            end
            default:
            begin
              s_d.reply.status = mpcd_pkg::STATUS_BAD_CMD;
            end
          endcase
        end
        s_d.reply.valid = (s_d.st == mpcd_pkg::ST_RECV);
      end

      // A restore copies the returned word back into the user variable
      mpcd_pkg::ST_NVM_WAIT:
      begin
        if (nvmAck)
        begin
          s_d.nvm.req = 1'b0;
          if (!s_q.nvm.write)
          begin
            globWrEn   = 1'b1;
            globWrAddr = s_q.nvm.addr;
            globWrData = nvmRdData;
          end
          s_d.reply.valid = 1'b1;
          s_d.st          = mpcd_pkg::ST_RECV;
        end
      end

      default:
      begin
        s_d.st = mpcd_pkg::ST_RECV;
      end
    endcase

    // Bytes are only taken while idle, which stalls the source during work
    s_d.rxReady = (s_d.st == mpcd_pkg::ST_RECV);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= mpcd_pkg::RST_REGS;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  assign rxReady     = s_q.rxReady;
  assign replyValid  = s_q.reply.valid;
  assign replyStatus = s_q.reply.status;
  assign replyInstr  = s_q.reply.instr;
  assign replyValue  = s_q.reply.value;
  assign accu        = s_q.accu;
  assign nvmReq      = s_q.nvm.req;
  assign nvmWrite    = s_q.nvm.write;
  assign nvmAddr     = s_q.nvm.addr;
  assign nvmWrData   = s_q.nvm.data;

endmodule

`default_nettype wire

// file: verification/mpcd_nvm_model.sv
// Behavioural non-volatile memory behind the decoder.
// Answers each request after 0 or 3 wait cycles; read data only valid with ack.
`timescale 1ns/1ps
`default_nettype none

module mpcd_nvm_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slowAck,
  input  wire logic        nvmReq,
  input  wire logic        nvmWrite,
  input  wire logic [9:0]  nvmAddr,
  input  wire logic [31:0] nvmWrData,
  output var  logic [31:0] nvmRdData,
  output var  logic        nvmAck
);
  logic [31:0] mem [1024];
  logic [1:0]  waitCnt;

  // ----------------------------------------------------------------
  // Stored image: a known pattern per address, survives reset
  // ----------------------------------------------------------------
  initial
  begin
    for (int k = 0; k < 1024; k++)
      mem[k] = 32'hA5A5_0000 | k;
  end

  // Skip the cycle after an ack, where the request is still seen high
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nvmAck <= 1'b0;
      waitCnt <= 2'd0;
      nvmRdData <= 32'h0000_0000;
    end
    else
    begin
      nvmAck <= 1'b0;
      nvmRdData <= ~nvmRdData; // Not valid outside the ack cycle
      if (nvmReq && !nvmAck)
      begin
        if (waitCnt == (slowAck ? 2'd3 : 2'd0))
        begin
          nvmAck <= 1'b1;
          waitCnt <= 2'd0;
          if (nvmWrite)
            mem[nvmAddr] <= nvmWrData;
          else
            nvmRdData <= mem[nvmAddr];
        end
        else
          waitCnt <= waitCnt + 2'd1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/mpcd_top_asserts.sv
// Assertion checker for the parameter command decoder, bound to mpcd_top.
// Sees only the top module's ports; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none

module mpcd_top_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  rxByte,
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [7:0]  serialAddr,
  input wire logic        standaloneMode,
  input wire logic        replyValid,
  input wire logic [7:0]  replyStatus,
  input wire logic [7:0]  replyInstr,
  input wire logic [31:0] replyValue,
  input wire logic [31:0] accu,
  input wire logic        nvmReq,
  input wire logic        nvmWrite,
  input wire logic [9:0]  nvmAddr,
  input wire logic [31:0] nvmWrData,
  input wire logic [31:0] nvmRdData,
  input wire logic        nvmAck
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Reply framing and memory handshake
  // ----------------------------------------------------------------
  reply_pulse_a: assert property (replyValid |=> !replyValid)
    else $error("reply strobe longer than one cycle");
  reply_ready_a: assert property (replyValid |-> rxReady && !nvmReq)
    else $error("reply while receiver or memory still busy");
  nvm_hold_a: assert property (nvmReq && !nvmAck |=> nvmReq && $stable(nvmAddr) && $stable(nvmWrite))
    else $error("memory request dropped or changed before acknowledge");
  nvm_write_end_a: assert property (nvmReq && nvmWrite && nvmAck |=> replyValid && !nvmReq)
    else $error("memory write not closed by a reply");
  nvm_busy_a: assert property (nvmReq |-> !rxReady)
    else $error("frame bytes accepted during memory access");
  // Only module globals and user variables ever reach the memory
  nvm_bank_a: assert property (nvmReq && nvmWrite |-> nvmAddr[9:8] == 2'b00 || nvmAddr[9:8] == 2'b10)
    else $error("memory write outside banks 0 and 2");

  // ----------------------------------------------------------------
  // Accumulator and reply values
  // ----------------------------------------------------------------
  accu_cause_a: assert property (!$stable(accu) |-> replyValid && replyStatus == mpcd_pkg::STATUS_OK
    && (replyInstr == mpcd_pkg::INSTR_GET_AXIS || replyInstr == mpcd_pkg::INSTR_GET_GLOBAL))
    else $error("accumulator changed without a good read");
  accu_value_a: assert property (!$stable(accu) |-> accu == replyValue)
    else $error("accumulator differs from value replied");
  write_zero_a: assert property (replyValid && replyStatus == mpcd_pkg::STATUS_OK
    && replyInstr inside {8'h05, 8'h09, 8'h0B, 8'h0C} |-> replyValue == 32'h0000_0000)
    else $error("write reply value not zero");
endmodule

bind mpcd_top mpcd_top_asserts i_mpcd_top_asserts (
  .clk(clk), .rst(rst), .rxByte(rxByte), .rxValid(rxValid), .rxReady(rxReady),
  .serialAddr(serialAddr), .standaloneMode(standaloneMode), .replyValid(replyValid),
  .replyStatus(replyStatus), .replyInstr(replyInstr), .replyValue(replyValue), .accu(accu),
  .nvmReq(nvmReq), .nvmWrite(nvmWrite), .nvmAddr(nvmAddr), .nvmWrData(nvmWrData),
  .nvmRdData(nvmRdData), .nvmAck(nvmAck)
);
`default_nettype wire

// file: verification/mpcd_top_tb.sv
// Self-checking bench for mpcd_top: the bench acts as the frame host,
// the memory model sits behind the block.
`timescale 1ns/1ps
`default_nettype none

module mpcd_top_tb;
  localparam logic [7:0] ME = 8'h01;
  localparam logic [7:0] OK = mpcd_pkg::STATUS_OK;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rxValid = 1'b0;
  logic        standaloneMode = 1'b0;
  logic        slowAck = 1'b0;
  logic [7:0]  rxByte = 8'h00;
  logic [7:0]  serialAddr = ME;
  logic        rxReady, replyValid, nvmReq, nvmWrite, nvmAck;
  logic [7:0]  replyStatus, replyInstr;
  logic [31:0] replyValue, accu, nvmWrData, nvmRdData;
  logic [31:0] expAccu = 32'h0000_0000;
  logic [9:0]  nvmAddr;
  int          failures = 0;
  int          numChecks = 0;

  mpcd_top i_mpcd_top (.clk(clk), .rst(rst), .rxByte(rxByte), .rxValid(rxValid), .rxReady(rxReady),
    .serialAddr(serialAddr), .standaloneMode(standaloneMode), .replyValid(replyValid),
    .replyStatus(replyStatus), .replyInstr(replyInstr), .replyValue(replyValue), .accu(accu),
    .nvmReq(nvmReq), .nvmWrite(nvmWrite), .nvmAddr(nvmAddr), .nvmWrData(nvmWrData),
    .nvmRdData(nvmRdData), .nvmAck(nvmAck));
  mpcd_nvm_model i_mpcd_nvm_model (.clk(clk), .rst(rst), .slowAck(slowAck), .nvmReq(nvmReq),
    .nvmWrite(nvmWrite), .nvmAddr(nvmAddr), .nvmWrData(nvmWrData), .nvmRdData(nvmRdData), .nvmAck(nvmAck));

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Checks %0d, failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Sends one frame; each byte held until the receiver takes it
  task automatic cmd(input logic [7:0] a, i, s, b, input logic [31:0] v, input logic [7:0] adj,
                     input logic [7:0] expSt, input logic [31:0] expVal, input logic expReply);
    logic [7:0] f [9];
    logic       got;
    int         n;
    f = '{a, i, s, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    f[8] = a + i + s + b + v[31:24] + v[23:16] + v[15:8] + v[7:0] + adj;
    @(posedge clk);
    for (int k = 0; k < 9; k++)
    begin
      rxByte <= f[k];
      rxValid <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (rxReady !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
        $display("Error at %0t: frame byte never taken", $time);
        failures++;
        test_done();
      end
    end
    rxValid <= 1'b0;
    got = 1'b0;
    for (n = 0; n < 60 && !got; n++)
    begin
      @(posedge clk);
      got = (replyValid === 1'b1);
    end
    @(negedge clk);
    check(got, expReply);
    if (got)
    begin
      check(replyStatus, expSt);
      check(replyInstr, i);
      if (expSt == OK)
        check(replyValue, expVal);
    end
    check(accu, expAccu);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic axisScn();
    cmd(ME, 8'h05, 8'h04, 8'h00, 32'hDEAD_BEEF, 8'h00, OK, 32'h0, 1'b1);
    cmd(ME, 8'h06, 8'h04, 8'h00, 32'h0, 8'h00, OK, 32'hDEAD_BEEF, 1'b1);
    @(posedge clk);
    standaloneMode <= 1'b1;
    expAccu = 32'hDEAD_BEEF;
    cmd(ME, 8'h06, 8'h04, 8'h00, 32'h0, 8'h00, OK, 32'hDEAD_BEEF, 1'b1);
    cmd(ME, 8'h05, 8'h04, 8'h01, 32'h1, 8'h00, mpcd_pkg::STATUS_BAD_MOTOR, 32'h0, 1'b1);
    @(posedge clk);
    standaloneMode <= 1'b0;
  endtask

  // Every legal bank written then read back; bank 0 must reach the memory
  task automatic globalScn();
    logic [7:0] banks [3];
    logic [31:0] v;
    banks = '{8'h00, 8'h02, 8'h03};
    slowAck <= 1'b1;
    foreach (banks[k])
    begin
      v = 32'hC0DE_0010 + k;
      cmd(ME, 8'h09, 8'h42, banks[k], v, 8'h00, OK, 32'h0, 1'b1);
      expAccu = v;
      cmd(ME, 8'h0A, 8'h42, banks[k], 32'h0, 8'h00, OK, v, 1'b1);
    end
    check(i_mpcd_nvm_model.mem[10'h042], 32'hC0DE_0010);
    cmd(ME, 8'h09, 8'h42, 8'h01, 32'h5, 8'h00, mpcd_pkg::STATUS_BAD_BANK, 32'h0, 1'b1);
    slowAck <= 1'b0;
  endtask

  task automatic storeScn();
    expAccu = 32'hA5A5_0205;
    cmd(ME, 8'h0A, 8'h05, 8'h02, 32'h0, 8'h00, OK, 32'hA5A5_0205, 1'b1);
    cmd(ME, 8'h09, 8'h2A, 8'h02, 32'h1111_2222, 8'h00, OK, 32'h0, 1'b1);
    cmd(ME, 8'h0B, 8'h2A, 8'h02, 32'hFFFF_FFFF, 8'h00, OK, 32'h0, 1'b1);
    check(i_mpcd_nvm_model.mem[10'h22A], 32'h1111_2222);
    cmd(ME, 8'h09, 8'h2A, 8'h02, 32'h3333_4444, 8'h00, OK, 32'h0, 1'b1);
    cmd(ME, 8'h0C, 8'h2A, 8'h02, 32'h0, 8'h00, OK, 32'h0, 1'b1);
    expAccu = 32'h1111_2222;
    cmd(ME, 8'h0A, 8'h2A, 8'h02, 32'h0, 8'h00, OK, 32'h1111_2222, 1'b1);
    cmd(ME, 8'h0B, 8'h2A, 8'h00, 32'h0, 8'h00, mpcd_pkg::STATUS_BAD_BANK, 32'h0, 1'b1);
  endtask

  // Refused frames must leave the accumulator alone
  task automatic errScn();
    cmd(ME, 8'h0A, 8'h05, 8'h02, 32'h0, 8'h01, mpcd_pkg::STATUS_BAD_SUM, 32'h0, 1'b1);
    cmd(ME + 8'h01, 8'h0A, 8'h05, 8'h02, 32'h0, 8'h00, OK, 32'h0, 1'b0);
    cmd(ME, 8'h02, 8'h00, 8'h00, 32'h0, 8'h00, mpcd_pkg::STATUS_BAD_CMD, 32'h0, 1'b1);
    expAccu = 32'hA5A5_0207;
    cmd(ME, 8'h0A, 8'h07, 8'h02, 32'h0, 8'h00, OK, 32'hA5A5_0207, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axisScn();
    globalScn();
    storeScn();
    errScn();
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    $display("Error at %0t: run limit reached", $time);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
